//--- adcsc_regs.vh
// constants for the serial conversion control block: control byte
// layout, mode codes, result framing and timing figures
// assumes a single core clock of 25 MHz driving all logic
`ifndef ADCSC_REGS_VH
`define ADCSC_REGS_VH

// control byte field positions, sent msb first
`define ADCSC_CTRL_START 7
`define ADCSC_CTRL_SEL_HI 6
`define ADCSC_CTRL_SEL_LO 4
`define ADCSC_CTRL_POL 3
`define ADCSC_CTRL_CFG 2
`define ADCSC_CTRL_PD_HI 1
`define ADCSC_CTRL_PD_LO 0

// power and clock mode codes
`define ADCSC_MODE_EXT 2'h3
`define ADCSC_MODE_INT 2'h2
`define ADCSC_MODE_FASTPD 2'h1
`define ADCSC_MODE_FULLPD 2'h0

// receive bit counts
`define ADCSC_RX_FIRST 4'h1
`define ADCSC_RX_LAST 4'h7
`define ADCSC_RX_TH_FROM 4'h5

// falls after the start fall: index of the fall before b3, last bit
`define ADCSC_FALL_PRE_B3 4'h6
`define ADCSC_FALL_LAST 4'hB

// result: 10 data bits plus 2 sub-lsb bits, framed in 16 bits
`define ADCSC_RES_W 12
`define ADCSC_OUT_W 16
`define ADCSC_OUT_PAD 3'h0

// timing, in nanoseconds
`define ADCSC_CLK_NS 40
`define ADCSC_INT_CONV_NS 10000
`define ADCSC_POR_NS 100000

`endif

//--- adcsc_sync3.v
// three-stage synchroniser for pins arriving from outside core_clk
// assumes the caller compares stage two and three before using a change
`timescale 1ns/100ps
`default_nettype none

module adcsc_sync3 #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // pins in
  input wire [W-1:0] pinIn,
  // stages two and three out
  output wire [W-1:0] stage2,
  output wire [W-1:0] stage3
);

  genvar i;

  // one chain per bit; stage one feeds nothing but stage two
  generate
    for (i = 0; i < W; i = i + 1) begin : gChain
      reg s1_r;
      reg s2_r;
      reg s3_r;
      always @(posedge core_clk) begin
        if (!rst_b) begin
          s1_r <= RST_VAL[i];
          s2_r <= RST_VAL[i];
          s3_r <= RST_VAL[i];
        end else begin
          s1_r <= pinIn[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      assign stage2[i] = s2_r;
      assign stage3[i] = s3_r;
    end
  endgenerate

endmodule // adcsc_sync3

`default_nettype wire

//--- adcsc_serial_ctrl.v
// serial control and readout logic of an 8-channel sar converter
// assumes the analog side presents a settled 12-bit straight-binary code
// on adcCode; the serial clock is slow enough to be oversampled here
`timescale 1ns/100ps
`default_nettype none
`include "adcsc_regs.vh"

// Summary of operation
// [RULE1] shift data in on each rising clock, select low
// [RULE2] leading zeros ignored; first one is start
// [RULE3] conversion starts on fall after eighth bit
// [RULE4] track while last three control bits arrive
// [RULE5] outputs change on falling clock, msb first
// [RULE6] external mode: strobe high one clock period
// [RULE7] twelve falls give ten data, two sub-lsb
// [RULE8] external conversion needs at least fifteen clocks
// [RULE9] select high floats outputs; fall drives strobe low; the strobe floats and is driven low by a select fall in external mode only
// [RULE10] unipolar straight binary, bipolar twos complement
// [RULE11] internal mode: strobe low while converting, bounded
// [RULE12] internal result held; first fall gives msb
// [RULE13] select high blocks input; internal conversion survives
// [RULE14] start accepted when idle or after b3 out
// [RULE15] select fall before b3 aborts, restarts conversion
// [RULE16] host sends sixteen zeros to resynchronise
// [RULE17] power-up in internal mode, strobe high, wait
// [RULE18] zeros shifted out before first conversion ends
// [RULE19] host minimal read: control byte, two zero bytes
// [RULE20] result framing: one zero, twelve bits, three zeros
// [RULE21] host keeps conversion short, clock in range
// [RULE22] host idles clock low, samples leading edge; the host model samples late in the high phase, just before the fall
// [RULE23] control byte: start, channel, polarity, config, mode
// [RULE24] mode field: ext, int, fast off, full off
module adcsc_serial_ctrl #(
  parameter INT_CONV_NS = `ADCSC_INT_CONV_NS,
  parameter POR_NS = `ADCSC_POR_NS
) (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // serial pins in
  input wire chipSelB,
  input wire sclkPin,
  input wire dinPin,
  // serial pins out
  output wire doutOut,
  output wire doutOe,
  output wire conversionStrobeOut,
  output wire conversionStrobeOe,
  // analog side
  input wire [11:0] adcCode,
  output wire trackHold,
  // decoded control byte
  output wire [2:0] channelSelect,
  output wire polaritySelect,
  output wire inputConfigSelect,
  output wire [1:0] powerClockMode,
  // status
  output wire convActive,
  output wire powerDown,
  output wire porBusy
);

  // longest conversion rounds down, reset wait rounds up
  localparam integer INT_CYC = INT_CONV_NS / `ADCSC_CLK_NS;
  localparam integer POR_CYC =
    (POR_NS + `ADCSC_CLK_NS - 1) / `ADCSC_CLK_NS;

  // one-hot converter states
  localparam [3:0] ST_POR = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_EXT = 4'h4;
  localparam [3:0] ST_INT = 4'h8;

  // synchronised pins: bit 0 clock, bit 1 select, bit 2 data
  wire [2:0] pinS2;
  wire [2:0] pinS3;
  reg [2:0] pinLvl_r; // last agreed level of each pin
  wire [2:0] agree;

  adcsc_sync3 #(
    .W(3),
    .RST_VAL(3'h2)
  ) uSync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn({dinPin, chipSelB, sclkPin}),
    .stage2(pinS2),
    .stage3(pinS3)
  );

  assign agree = pinS2 ~^ pinS3;

  // a pin change counts once stages two and three agree
  always @(posedge core_clk) begin
    if (!rst_b) begin
      pinLvl_r <= 3'h2;
    end else begin
      pinLvl_r <= (agree & pinS3) | (~agree & pinLvl_r);
    end
  end

  wire csLow = ~pinLvl_r[1]; // select asserted
  wire sclkRise = agree[0] & pinS3[0] & ~pinLvl_r[0];
  wire sclkFall = agree[0] & ~pinS3[0] & pinLvl_r[0];
  wire csFall = agree[1] & ~pinS3[1] & pinLvl_r[1];
  wire dinBit = pinS3[2]; // settled with the same latency as the clock

  // receiver state
  reg rxActive_r; // collecting a control byte
  reg rxFull_r; // eight bits in, waiting for the start fall
  reg [3:0] rxCnt_r; // bits taken so far
  reg [7:0] rxSr_r; // control byte shift register
  reg th_r; // track/hold in acquire

  // converter state
  reg [3:0] state_r;
  reg [12:0] cycCnt_r; // core cycles in reset wait or internal conversion
  reg [3:0] fallCnt_r; // falls since the external start fall
  reg b3Done_r; // b3 has left the data pin
  reg [`ADCSC_OUT_W-1:0] outSr_r; // result framing shifter
  reg [`ADCSC_RES_W-1:0] code_r; // held sample, formatted
  reg strobe_r;
  reg extMode_r; // conversion in play uses the serial clock
  reg lastClkInt_r; // clock mode kept for power-down requests
  reg pdAfter_r; // power down once this conversion completes
  reg powerDown_r;
  reg [2:0] chan_r;
  reg pol_r;
  reg cfg_r;
  reg [1:0] mode_r;

  // new start bits: when idle, or once b3 is out [RULE14]
  wire huntOk = (state_r == ST_IDLE) | ((state_r == ST_EXT) & b3Done_r);
  // conversion begins on the fall after the eighth bit [RULE3]
  wire startFall = sclkFall & rxFull_r & csLow;
  // control byte fields as they stand in the shift register [RULE23]
  wire [1:0] newMode = rxSr_r[`ADCSC_CTRL_PD_HI:`ADCSC_CTRL_PD_LO];
  // power-down codes convert in the last clock mode chosen [RULE24]
  wire newExt = newMode[1] ? newMode[0] : ~lastClkInt_r;
  // bipolar flips the msb of the offset code [RULE10]
  wire [`ADCSC_RES_W-1:0] fmtCode = rxSr_r[`ADCSC_CTRL_POL] ? adcCode :
    {~adcCode[`ADCSC_RES_W-1], adcCode[`ADCSC_RES_W-2:0]};

  // receiver: a raised select blocks input and drops a partial byte
  always @(posedge core_clk) begin
    if (!rst_b) begin
      rxActive_r <= 1'b0;
      rxFull_r <= 1'b0;
      rxCnt_r <= 4'h0;
      rxSr_r <= 8'h00;
      th_r <= 1'b0;
    end else if (!csLow) begin // [RULE13]
      rxActive_r <= 1'b0;
      rxFull_r <= 1'b0;
      th_r <= 1'b0;
    end else if (startFall) begin
      rxFull_r <= 1'b0; // hold begins here
      th_r <= 1'b0;
    end else if (sclkRise) begin // data taken on rising clock [RULE1]
      if (rxActive_r) begin
        rxSr_r <= {rxSr_r[6:0], dinBit};
        rxCnt_r <= rxCnt_r + 4'h1;
        // acquire over the last three bits [RULE4]
        if (rxCnt_r == `ADCSC_RX_TH_FROM) begin
          th_r <= 1'b1;
        end
        if (rxCnt_r == `ADCSC_RX_LAST) begin
          rxActive_r <= 1'b0;
          rxFull_r <= 1'b1;
        end
      end else if (dinBit & huntOk & ~rxFull_r) begin
        // zeros before it are dropped; this one is the msb [RULE2]
        rxActive_r <= 1'b1;
        rxSr_r <= 8'h01;
        rxCnt_r <= `ADCSC_RX_FIRST;
      end
    end
  end

  // converter sequencing and outputs
  always @(posedge core_clk) begin
    if (!rst_b) begin
      // power-up: internal clock mode, strobe high [RULE17]
      state_r <= ST_POR;
      cycCnt_r <= 13'h0000;
      fallCnt_r <= 4'h0;
      b3Done_r <= 1'b0;
      outSr_r <= 16'h0000; // zeros until a result exists [RULE18]
      code_r <= 12'h000;
      strobe_r <= 1'b1;
      extMode_r <= 1'b0;
      lastClkInt_r <= 1'b1;
      pdAfter_r <= 1'b0;
      powerDown_r <= 1'b0;
      chan_r <= 3'h0;
      pol_r <= 1'b0;
      cfg_r <= 1'b0;
      mode_r <= `ADCSC_MODE_INT;
    end else if (startFall) begin
      // start restarts whatever was running [RULE3]
      chan_r <= rxSr_r[`ADCSC_CTRL_SEL_HI:`ADCSC_CTRL_SEL_LO];
      pol_r <= rxSr_r[`ADCSC_CTRL_POL];
      cfg_r <= rxSr_r[`ADCSC_CTRL_CFG];
      mode_r <= newMode;
      if (newMode[1]) begin
        lastClkInt_r <= ~newMode[0];
      end
      pdAfter_r <= ~newMode[1];
      powerDown_r <= 1'b0; // a start bit wakes the converter
      code_r <= fmtCode;
      extMode_r <= newExt;
      fallCnt_r <= 4'h0;
      b3Done_r <= 1'b0;
      cycCnt_r <= 13'h0000;
      if (newExt) begin
        state_r <= ST_EXT;
        strobe_r <= 1'b1; // one serial period high [RULE6]
        // one zero, twelve bits, three zeros [RULE20]
        outSr_r <= {1'b0, fmtCode, `ADCSC_OUT_PAD};
      end else begin
        state_r <= ST_INT;
        strobe_r <= 1'b0; // low while converting [RULE11]
      end
    end else begin
      case (state_r)
        ST_POR: begin
          // host stays off the link during this wait [RULE17]
          if (cycCnt_r == POR_CYC[12:0] - 13'h0001) begin
            state_r <= ST_IDLE;
          end else begin
            cycCnt_r <= cycCnt_r + 13'h0001;
          end
        end
        ST_EXT: begin
          if (csFall & ~b3Done_r) begin
            // too early a restart abandons this conversion [RULE15]
            state_r <= ST_IDLE;
            strobe_r <= 1'b0;
            outSr_r <= 16'h0000;
          end else if (sclkFall & csLow) begin // [RULE5]
            strobe_r <= 1'b0;
            // one decision per fall, msb first [RULE7]
            outSr_r <= {outSr_r[`ADCSC_OUT_W-2:0], 1'b0};
            fallCnt_r <= fallCnt_r + 4'h1;
            // b3 out after the seventh fall; fifteen clocks least [RULE8]
            if (fallCnt_r == `ADCSC_FALL_PRE_B3) begin
              b3Done_r <= 1'b1;
            end
            if (fallCnt_r == `ADCSC_FALL_LAST) begin
              state_r <= ST_IDLE;
              powerDown_r <= pdAfter_r;
            end
          end else if (csFall) begin
            strobe_r <= 1'b0; // driven low after select falls [RULE9]
          end
        end
        ST_INT: begin
          // select does not disturb this conversion [RULE13]
          if (cycCnt_r == INT_CYC[12:0] - 13'h0001) begin
            state_r <= ST_IDLE;
            strobe_r <= 1'b1;
            powerDown_r <= pdAfter_r;
            // result held until clocked out [RULE12]
            outSr_r <= {1'b0, code_r, `ADCSC_OUT_PAD};
          end else begin
            cycCnt_r <= cycCnt_r + 13'h0001;
          end
        end
        ST_IDLE: begin
          if (sclkFall & csLow) begin
            // held result, or trailing zeros, leave on falls [RULE5]
            outSr_r <= {outSr_r[`ADCSC_OUT_W-2:0], 1'b0};
            if (extMode_r) begin
              strobe_r <= 1'b0;
            end
          end else if (csFall & extMode_r) begin
            strobe_r <= 1'b0; // [RULE9]
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // first internal-mode fall after completion already shows the msb:
  // the leading pad zero sits ahead of it in both framings
  reg intLead_r;
  always @(posedge core_clk) begin
    if (!rst_b) begin
      intLead_r <= 1'b0;
    end else if (startFall) begin
      intLead_r <= 1'b0;
    end else if (state_r == ST_INT) begin
      intLead_r <= (cycCnt_r == INT_CYC[12:0] - 13'h0001);
    end else if (sclkFall & csLow) begin
      intLead_r <= 1'b0;
    end
  end

  // pins: data floats with select high [RULE9]
  assign doutOut = (intLead_r & ~extMode_r) ? 1'b0 :
    outSr_r[`ADCSC_OUT_W-1];
  assign doutOe = csLow; // [RULE13]
  assign conversionStrobeOut = strobe_r;
  // strobe floats only in external mode [RULE9] [RULE13]
  assign conversionStrobeOe = extMode_r ? csLow : 1'b1;

  assign trackHold = th_r;
  assign channelSelect = chan_r;
  assign polaritySelect = pol_r;
  assign inputConfigSelect = cfg_r;
  assign powerClockMode = mode_r;
  assign convActive = (state_r == ST_EXT) | (state_r == ST_INT);
  assign powerDown = powerDown_r;
  assign porBusy = (state_r == ST_POR);

endmodule // adcsc_serial_ctrl

`default_nettype wire

//--- adcsc_serial_ctrl_assertions.sv
// checker for the serial conversion control block, bound to its top
// assumes the serial clock period is eight core clocks, as in the bench
`timescale 1ns/100ps
`default_nettype none
module adcsc_chk #(
  parameter INT_CONV_NS = 10000
) (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // serial pins
  input wire chipSelB,
  input wire sclkPin,
  input wire doutOut,
  input wire doutOe,
  input wire conversionStrobeOut,
  input wire conversionStrobeOe,
  // analog side and status
  input wire trackHold,
  input wire [1:0] powerClockMode,
  input wire convActive,
  input wire porBusy
);
  // longest internal strobe low, with slack for pin latency
  localparam int LOW_MAX = INT_CONV_NS / 40 + 5;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // strobe pulse of one serial period, eight core clocks
  sequence s_pulse;
    conversionStrobeOut [*8] ##1 !conversionStrobeOut;
  endsequence
  // track from sixth bit rise to the start fall, 2.5 periods
  sequence s_track;
    trackHold [*8] ##[12:14] !trackHold;
  endsequence
  a_por_state: assert property (porBusy |-> conversionStrobeOut &&
    powerClockMode == 2'h2 && !convActive) else $error("reset state bad");
  a_int_oe: assert property (powerClockMode == 2'h2 |->
    conversionStrobeOe) else $error("internal strobe floated");
  a_ext_oe: assert property ($stable(chipSelB) [*5] &&
    powerClockMode == 2'h3 |-> conversionStrobeOe == !chipSelB)
    else $error("external strobe enable wrong");
  a_dout_float: assert property (chipSelB [*5] |-> !doutOe)
    else $error("dout driven while deselected");
  // pins reach the outputs four core clocks late, so the serial clock
  // is judged as it stood when the block saw the edge
  a_strobe_edge: assert property ($changed(conversionStrobeOut) &&
    powerClockMode == 2'h3 |-> !$past(sclkPin, 4))
    else $error("strobe moved off a falling clock");
  a_dout_edge: assert property ($changed(doutOut) && doutOe |->
    !$past(sclkPin, 4)) else $error("dout moved on rising clock");
  a_ext_pulse: assert property ($rose(conversionStrobeOut) &&
    powerClockMode == 2'h3 |-> s_pulse) else $error("strobe pulse length");
  a_track_win: assert property ($rose(trackHold) |-> s_track)
    else $error("track window wrong");
  // the strobe may already be low when an internal conversion starts,
  // so the start is taken from the activity flag instead
  a_int_low: assert property ($rose(convActive) &&
    powerClockMode == 2'h2 |-> !conversionStrobeOut ##[1:LOW_MAX]
    conversionStrobeOut) else $error("internal conversion too long");
endmodule // adcsc_chk
bind adcsc_serial_ctrl adcsc_chk #(.INT_CONV_NS(INT_CONV_NS)) adcsc_chk_i (
  .core_clk(core_clk), .rst_b(rst_b), .chipSelB(chipSelB),
  .sclkPin(sclkPin), .doutOut(doutOut), .doutOe(doutOe),
  .conversionStrobeOut(conversionStrobeOut),
  .conversionStrobeOe(conversionStrobeOe), .trackHold(trackHold),
  .powerClockMode(powerClockMode), .convActive(convActive),
  .porBusy(porBusy));
`default_nettype wire

//--- adcsc_host.sv
// host serial master model: select, clock and data towards the block
// assumes the bench calls its tasks; pins change at core clock falls
`timescale 1ns/100ps
`default_nettype none
module adcsc_host (
  // clock
  input wire core_clk,
  // data back from the block
  input wire doutOut,
  input wire doutOe,
  // pins driven by the host
  output logic chipSelB,
  output logic sclkPin,
  output logic dinPin
);
  logic lastDout = 1'b0; // last driven level of the data line
  // a floated line shows the inverse, so a stale bit never matches
  wire doutLine = doutOe ? doutOut : ~lastDout;
  // remember what the block drove
  always @(posedge core_clk) begin
    if (doutOe) lastDout <= doutOut;
  end
  // idle: deselected, clock still and low
  initial begin
    chipSelB = 1'b1;
    sclkPin = 1'b0;
    dinPin = 1'b0;
  end
  // half a serial period, 160 ns; a whole conversion then stays far
  // inside the droop limit
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask
  // one byte msb first; bit taken late in the high phase, where it
  // is settled, since it stands until the next fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      dinPin = tx[i];
      half();
      sclkPin = 1'b1;
      half();
      rx[i] = doutLine;
      sclkPin = 1'b0;
    end
  endtask
  // select level, then a full period for the pin to settle
  task automatic sel(input logic lvl);
    chipSelB = lvl;
    half();
    half();
  endtask
endmodule // adcsc_host
`default_nettype wire

//--- tb_top.sv
// bench for the serial conversion control block with a host model
// assumes shortened conversion and reset waits of 400 ns
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0; // 25 MHz core clock
  logic rst_b = 1'b0; // synchronous reset, held 3 cycles
  logic [11:0] adcCode = 12'hA5C; // analog code offered
  wire chipSelB, sclkPin, dinPin, doutOut, doutOe, trackHold;
  wire conversionStrobeOut, conversionStrobeOe, polaritySelect;
  wire inputConfigSelect, convActive, powerDown, porBusy;
  wire [2:0] channelSelect;
  wire [1:0] powerClockMode;
  int n_fail = 0;
  int num_checks = 0;
  logic [7:0] r1, r2, r3; // bytes back from the block
  initial forever #20 core_clk = ~core_clk;
  adcsc_serial_ctrl #(.INT_CONV_NS(400), .POR_NS(400)) adcsc_serial_ctrl_i (
    .core_clk(core_clk), .rst_b(rst_b), .chipSelB(chipSelB),
    .sclkPin(sclkPin), .dinPin(dinPin), .doutOut(doutOut), .doutOe(doutOe),
    .conversionStrobeOut(conversionStrobeOut),
    .conversionStrobeOe(conversionStrobeOe), .adcCode(adcCode),
    .trackHold(trackHold), .channelSelect(channelSelect),
    .polaritySelect(polaritySelect), .inputConfigSelect(inputConfigSelect),
    .powerClockMode(powerClockMode), .convActive(convActive),
    .powerDown(powerDown), .porBusy(porBusy));
  adcsc_host adcsc_host_i (.core_clk(core_clk), .doutOut(doutOut),
    .doutOe(doutOe), .chipSelB(chipSelB), .sclkPin(sclkPin),
    .dinPin(dinPin));
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // compare seen against expected
  task automatic check(input logic [15:0] seen, exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // bounded wait for the strobe; running out ends the run
  task automatic wait_strobe(input logic lvl);
    int k;
    for (k = 0; k < 100 && conversionStrobeOut !== lvl; k++)
      @(negedge core_clk);
    if (k == 100) begin
      check(1, 0, "strobe timeout");
      stop_test();
    end
  endtask
  // three-byte external read, result framed in bytes two and three
  task automatic ext_read(input logic [7:0] ctrl, input logic [15:0] exp);
    adcsc_host_i.sel(1'b0);
    fork
      adcsc_host_i.xfer(ctrl, r1);
      begin
        // before the sixth bit is seen, then during the last three
        repeat (40) @(negedge core_clk);
        check(trackHold, 0, "track early");
        repeat (16) @(negedge core_clk);
        check(trackHold, 1, "track late");
      end
    join
    adcsc_host_i.xfer(8'h00, r2);
    adcsc_host_i.xfer(8'h00, r3);
    adcsc_host_i.sel(1'b1);
    check({r2, r3}, exp, "result frame");
  endtask
  // first read after reset, led by sixteen zeros
  task automatic t_ext();
    adcsc_host_i.sel(1'b0);
    adcsc_host_i.xfer(8'h00, r1);
    adcsc_host_i.xfer(8'h00, r1);
    check(convActive, 0, "zeros started work");
    check(r1, 8'h00, "early output");
    adcsc_host_i.sel(1'b1);
    ext_read(8'hFF, {1'b0, adcCode, 3'h0});
    check(r1, 8'h00, "byte during control");
    check({channelSelect, polaritySelect, inputConfigSelect,
      powerClockMode}, 7'h7F, "fields");
    check({doutOe, conversionStrobeOe}, 0, "float");
    $display("test ext done");
  endtask
  // bipolar differential on channel two
  task automatic t_bip();
    adcCode = 12'h3A1;
    ext_read(8'hA3, {1'b0, 12'hBA1, 3'h0});
    check({channelSelect, polaritySelect, inputConfigSelect},
      5'h08, "bipolar fields");
    $display("test bip done");
  endtask
  // reselect before bit three is out: old conversion dropped
  task automatic t_abort();
    adcCode = 12'h123;
    adcsc_host_i.sel(1'b0);
    adcsc_host_i.xfer(8'hFF, r1);
    adcsc_host_i.sel(1'b1);
    ext_read(8'h9F, {1'b0, 12'h123, 3'h0});
    check(channelSelect, 1, "new channel");
    $display("test abort done");
  endtask
  // both power-down codes convert in external mode, then power down
  task automatic t_pd();
    logic [7:0] codes [2] = '{8'hFD, 8'hFC};
    foreach (codes[i]) begin
      ext_read(codes[i], {1'b0, adcCode, 3'h0});
      check({powerClockMode, powerDown}, {codes[i][1:0], 1'b1},
        "power down");
    end
    $display("test pd done");
  endtask
  // internal clock conversion survives deselect, then is read
  task automatic t_int();
    adcCode = 12'h5A6;
    adcsc_host_i.sel(1'b0);
    adcsc_host_i.xfer(8'hBE, r1);
    adcsc_host_i.sel(1'b1);
    check({conversionStrobeOut, conversionStrobeOe, doutOe}, 3'h2,
      "converting");
    wait_strobe(1'b1);
    adcsc_host_i.sel(1'b0);
    adcsc_host_i.xfer(8'h00, r2);
    adcsc_host_i.xfer(8'h00, r3);
    adcsc_host_i.sel(1'b1);
    check({r2, r3}, {1'b0, 12'h5A6, 3'h0}, "held result");
    $display("test int done");
  endtask
  // main sequence
  initial begin
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    @(negedge core_clk);
    check({conversionStrobeOut, powerClockMode}, 3'h6, "reset");
    for (int k = 0; k < 100 && porBusy !== 1'b0; k++) @(negedge core_clk);
    check(porBusy, 0, "reset wait");
    if (porBusy !== 1'b0) stop_test();
    $display("test reset done");
    t_ext();
    t_bip();
    t_abort();
    t_pd();
    t_int();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
